// file: pkg/bchr_defs.svh
// Offsets, fixed field values and reset values of the bridge header slice
`ifndef BCHR_DEFS_SVH
`define BCHR_DEFS_SVH

`define BCHR_OFF_CLASS 8'h08
`define BCHR_OFF_MISC 8'h0C
`define BCHR_OFF_BUS 8'h18
`define BCHR_OFF_IO 8'h1C

`define BCHR_PROG_IF 8'h00
`define BCHR_SUB_CLASS 8'h04
`define BCHR_BASE_CLASS 8'h06
`define BCHR_HDR_FN0 8'h81
`define BCHR_HDR_FN1 8'h01
`define BCHR_IO_32BIT 4'h1
`define BCHR_IO_LOW_BASE 12'h000
`define BCHR_IO_LOW_LIMIT 12'hFFF
`define BCHR_CLS_MAX 8'h10

`define BCHR_RST_BYTE 8'h00
`define BCHR_RST_NIB 4'h0
`define BCHR_RST_WORD 32'h0000_0000

`endif

// file: pkg/bchr_pkg.sv
// Types shared by the bridge header slice
package bchr_pkg;

    typedef logic [1:0][7:0] bchr_byte_pair_type;
    typedef logic [1:0][3:0] bchr_nib_pair_type;

    typedef struct packed {
        logic [31:0] rdata;
        bchr_byte_pair_type cls;
        bchr_byte_pair_type plat;
        bchr_byte_pair_type pbus;
        bchr_byte_pair_type sbus;
        bchr_byte_pair_type subus;
        bchr_byte_pair_type slat;
        bchr_nib_pair_type iob;
        bchr_nib_pair_type iol;
        logic [1:0] hit;
    } bchr_state_type;

endpackage : bchr_pkg

// file: verilog/bchr_regs.sv
// Configuration header slice 08h-1Ch of both bridge functions
// Function
// - Programming interface byte of class code always reads zero.
// - Sub-class byte is read-only and reads the PCI-to-PCI bridge value.
// - Base-class byte is read-only and reads the bridge device value.
// - Writable cache line length, reset zero, steers write-invalidate ends and prefetch.
// - Writable primary latency value, reset zero, loads the master latency timer.
// - Function 0 header type is read-only multifunction bridge value.
// - Function 1 header type is read-only single-function bridge value.
// - Writable primary bus number, reset zero, set by software.
// - Per-function writable secondary bus number, reset zero.
// - Per-function writable subordinate bus number, reset zero.
// - Writable secondary latency value, reset zero, times unclaimed secondary accesses.
// - Low nibble of I/O base reads one for 32-bit I/O.
// - Writable upper nibble of I/O base gives window bottom bits 15:12.
// - Window bottom bits 31:16 come from a separate upper base register.
// - I/O base is the lowest address of the forwarded range.
// - Window top takes its low twelve bits as all ones.
//
// The implementer's own choice: the plain strobed port.
`include "bchr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module bchr_regs
    import bchr_pkg::*;
#(
    // Arbitrary value, read back as the revision byte of the class code register at 08h
    parameter logic [7:0] REV_ID = 8'h00
) (
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    input wire logic [7:0] I_ADDR,
    input wire logic I_FUNC,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_BYTE_EN,
    input wire logic I_WRITE,
    input wire logic I_READ,
    input wire logic [31:0] I_IO_ADDR,
    input wire logic [31:0] I_IO_BASE_UPPER,
    input wire logic [31:0] I_IO_LIMIT_UPPER,
    output logic [31:0] O_RDATA,
    output logic [15:0] O_CACHELINE_LEN,
    output logic [1:0] O_CACHELINE_OK,
    output logic [15:0] O_UP_HOLD_TIMER,
    output logic [15:0] O_DOWN_UNCLAIMED_TIMER,
    output logic [15:0] O_UP_BUS_INDEX,
    output logic [15:0] O_DOWN_BUS_INDEX,
    output logic [15:0] O_HIGHEST_BUS_INDEX,
    output logic [1:0] O_IO_HIT
);

    function automatic logic [7:0] lane_wr(input logic [7:0] old_val,
                                           input logic [7:0] new_val,
                                           input logic en);
        lane_wr = en ? new_val : old_val;
    endfunction : lane_wr

    function automatic logic cls_legal(input logic [7:0] v);
        cls_legal = (v == 8'h00) || ((v <= `BCHR_CLS_MAX) && ((v & (v - 8'h01)) == 8'h00));
    endfunction : cls_legal

    function automatic logic [7:0] hdr_type(input logic fn);
        hdr_type = fn ? `BCHR_HDR_FN1 : `BCHR_HDR_FN0;
    endfunction : hdr_type

    bchr_state_type state_reg;
    bchr_state_type state_next;
    logic [31:0] base_full [2];
    logic [31:0] limit_full [2];

    always_comb begin
        for (int f = 0; f < 2; f++) begin
            // Upper half lives in a separate register outside this slice
            base_full[f] = {I_IO_BASE_UPPER[16*f +: 16], state_reg.iob[f],
                            `BCHR_IO_LOW_BASE};
            limit_full[f] = {I_IO_LIMIT_UPPER[16*f +: 16], state_reg.iol[f],
                             `BCHR_IO_LOW_LIMIT};
        end
    end

    always_comb begin
        logic fn;
        fn = I_FUNC;
        state_next = state_reg;
        state_next.rdata = `BCHR_RST_WORD;
        if (I_READ) begin
            unique case (I_ADDR)
                `BCHR_OFF_CLASS: begin
                    state_next.rdata = {`BCHR_BASE_CLASS, `BCHR_SUB_CLASS,
                                        `BCHR_PROG_IF, REV_ID};
                end
                `BCHR_OFF_MISC: begin
                    state_next.rdata = {8'h00, hdr_type(fn), state_reg.plat[fn],
                                        state_reg.cls[fn]};
                end
                `BCHR_OFF_BUS: begin
                    state_next.rdata = {state_reg.slat[fn], state_reg.subus[fn],
                                        state_reg.sbus[fn], state_reg.pbus[fn]};
                end
                `BCHR_OFF_IO: begin
                    // Secondary status in the upper half is outside this slice
                    state_next.rdata = {16'h0000, state_reg.iol[fn], `BCHR_IO_32BIT,
                                        state_reg.iob[fn], `BCHR_IO_32BIT};
                end
                default: begin
                    state_next.rdata = `BCHR_RST_WORD;
                end
            endcase
        end
        if (I_WRITE) begin
            unique case (I_ADDR)
                `BCHR_OFF_MISC: begin
                    // Illegal lengths are stored as written and flagged, not fixed up
                    state_next.cls[fn] = lane_wr(state_reg.cls[fn], I_WDATA[7:0],
                                                 I_BYTE_EN[0]);
                    state_next.plat[fn] = lane_wr(state_reg.plat[fn], I_WDATA[15:8],
                                                  I_BYTE_EN[1]);
                end
                `BCHR_OFF_BUS: begin
                    state_next.pbus[fn] = lane_wr(state_reg.pbus[fn], I_WDATA[7:0],
                                                  I_BYTE_EN[0]);
                    state_next.sbus[fn] = lane_wr(state_reg.sbus[fn], I_WDATA[15:8],
                                                  I_BYTE_EN[1]);
                    state_next.subus[fn] = lane_wr(state_reg.subus[fn], I_WDATA[23:16],
                                                   I_BYTE_EN[2]);
                    state_next.slat[fn] = lane_wr(state_reg.slat[fn], I_WDATA[31:24],
                                                  I_BYTE_EN[3]);
                end
                `BCHR_OFF_IO: begin
                    if (I_BYTE_EN[0]) begin
                        state_next.iob[fn] = I_WDATA[7:4];
                    end
                    if (I_BYTE_EN[1]) begin
                        state_next.iol[fn] = I_WDATA[15:12];
                    end
                end
                default: begin
                end
            endcase
        end
        for (int f = 0; f < 2; f++) begin
            state_next.hit[f] = (I_IO_ADDR >= base_full[f]) &&
                                (I_IO_ADDR <= limit_full[f]);
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_RDATA = state_reg.rdata;
    assign O_CACHELINE_LEN = state_reg.cls;
    assign O_CACHELINE_OK = {cls_legal(state_reg.cls[1]), cls_legal(state_reg.cls[0])};
    assign O_UP_HOLD_TIMER = state_reg.plat;
    assign O_DOWN_UNCLAIMED_TIMER = state_reg.slat;
    assign O_UP_BUS_INDEX = state_reg.pbus;
    assign O_DOWN_BUS_INDEX = state_reg.sbus;
    assign O_HIGHEST_BUS_INDEX = state_reg.subus;
    assign O_IO_HIT = state_reg.hit;

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RESETN);

    sequence s_rd(logic [7:0] off);
        I_READ && (I_ADDR == off);
    endsequence

    sequence s_wr(logic [7:0] off, int lane);
        I_WRITE && (I_ADDR == off) && I_BYTE_EN[lane];
    endsequence

    a_class_code_read: assert property (
        s_rd(`BCHR_OFF_CLASS) |=> O_RDATA[31:8] == 24'h06_0400)
        else $error("class code read wrong");

    a_header_type_read: assert property (
        s_rd(`BCHR_OFF_MISC) |=>
            O_RDATA[23:16] == ($past(I_FUNC) ? 8'h01 : 8'h81))
        else $error("header type read wrong");

    a_io_indicator_read: assert property (
        s_rd(`BCHR_OFF_IO) |=> (O_RDATA[3:0] == 4'h1) && (O_RDATA[11:8] == 4'h1))
        else $error("io indicator not one");

    a_cacheline_write: assert property (
        s_wr(`BCHR_OFF_MISC, 0) |=>
            O_CACHELINE_LEN[8*$past(I_FUNC) +: 8] == $past(I_WDATA[7:0]))
        else $error("cache line length not stored");

    a_cacheline_flag: assert property (
        O_CACHELINE_LEN[7:0] == 8'h03 |-> !O_CACHELINE_OK[0])
        else $error("illegal cache line accepted");

    a_latency_write: assert property (
        s_wr(`BCHR_OFF_MISC, 1) |=>
            O_UP_HOLD_TIMER[8*$past(I_FUNC) +: 8] == $past(I_WDATA[15:8]))
        else $error("primary latency not stored");

    a_sec_latency_write: assert property (
        s_wr(`BCHR_OFF_BUS, 3) |=>
            O_DOWN_UNCLAIMED_TIMER[8*$past(I_FUNC) +: 8] == $past(I_WDATA[31:24]))
        else $error("secondary latency not stored");

    // The master leaves one idle cycle between strobes, hence the two-cycle gap
    a_bus_number_rw: assert property (
        s_wr(`BCHR_OFF_BUS, 1)
            ##2 (I_READ && (I_ADDR == `BCHR_OFF_BUS) && (I_FUNC == $past(I_FUNC, 2)))
            |=> O_RDATA[15:8] == $past(I_WDATA[15:8], 3))
        else $error("secondary bus number readback wrong");

    a_lane_untouched: assert property (
        I_WRITE && (I_ADDR == `BCHR_OFF_BUS) && !I_BYTE_EN[3] && !I_FUNC
            |=> $stable(O_DOWN_UNCLAIMED_TIMER[7:0]))
        else $error("disabled lane was written");

    a_window_hit: assert property (
        (I_IO_ADDR[31:12] == {I_IO_BASE_UPPER[15:0], state_reg.iob[0]})
            && ({I_IO_LIMIT_UPPER[15:0], state_reg.iol[0]}
                >= {I_IO_BASE_UPPER[15:0], state_reg.iob[0]})
            && (I_IO_LIMIT_UPPER[15:0] == I_IO_BASE_UPPER[15:0]) ##1 $stable(state_reg.iob[0])
            |-> O_IO_HIT[0])
        else $error("address in window missed");

    a_read_one_cycle: assert property (
        !I_READ |=> O_RDATA == 32'h0000_0000)
        else $error("read data outside its cycle");

endmodule : bchr_regs

`default_nettype wire

// file: testbench/bchr_upper_model.sv
// Model of the external upper I/O base and limit registers beside the header slice
`timescale 1ns/1ps
`default_nettype none

module bchr_upper_model (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_load,
    input wire logic [31:0] i_base,
    input wire logic [31:0] i_limit,
    output logic [31:0] o_base_upper,
    output logic [31:0] o_limit_upper
);
    // Zero at reset keeps an unprogrammed window inside the lowest 64 KiB
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_base_upper <= 32'h0000_0000;
            o_limit_upper <= 32'h0000_0000;
        end else if (i_load) begin
            o_base_upper <= i_base;
            o_limit_upper <= i_limit;
        end
    end
endmodule : bchr_upper_model
`default_nettype wire

// file: testbench/testbench.sv
// Register access and I/O window tests for the bridge header slice
`include "bchr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic func = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] io_addr = 32'h0000_0000;
    logic ld = 1'b0;
    logic [31:0] bu;
    logic [31:0] lu;
    logic [31:0] rdata;
    logic [15:0] cl_len, up_t, dn_t, up_b, dn_b, hi_b;
    logic [1:0] cl_ok, hit;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] io_tab [6] = '{32'h0001_4FFF, 32'h0001_5000, 32'h0001_7FFF,
        32'h0001_8000, 32'h0000_0FFF, 32'h0000_1000};
    logic [1:0] hit_tab [6] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h0};

    always #2 clk = ~clk;

    bchr_upper_model bchr_upper_model_i (.i_clock(clk), .i_resetn(rst_n), .i_load(ld),
        .i_base(32'h0000_0001), .i_limit(32'h0000_0001), .o_base_upper(bu),
        .o_limit_upper(lu));

    bchr_regs bchr_regs_i (.I_CLOCK(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_FUNC(func),
        .I_WDATA(wdata), .I_BYTE_EN(be), .I_WRITE(wr_s), .I_READ(rd_s), .I_IO_ADDR(io_addr),
        .I_IO_BASE_UPPER(bu), .I_IO_LIMIT_UPPER(lu), .O_RDATA(rdata),
        .O_CACHELINE_LEN(cl_len), .O_CACHELINE_OK(cl_ok), .O_UP_HOLD_TIMER(up_t),
        .O_DOWN_UNCLAIMED_TIMER(dn_t), .O_UP_BUS_INDEX(up_b), .O_DOWN_BUS_INDEX(dn_b),
        .O_HIGHEST_BUS_INDEX(hi_b), .O_IO_HIT(hit));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] e,
        input logic [31:0] d);
        @(posedge clk);
        {func, addr, be, wdata, wr_s} <= {f, a, e, d, 1'b1};
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    // Read data is only valid in the single cycle after the strobe
    task automatic rd(input logic f, input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        {func, addr, rd_s} <= {f, a, 1'b1};
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #20000;
        err_total++;
        final_report();
    end

    initial begin
        logic [31:0] v;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int f = 0; f < 2; f++) begin
            rd(f[0], `BCHR_OFF_CLASS, v); check(v, 32'h0604_0000);
            rd(f[0], `BCHR_OFF_MISC, v); check(v, f ? 32'h0001_0000 : 32'h0081_0000);
            rd(f[0], `BCHR_OFF_BUS, v); check(v, 32'h0000_0000);
            rd(f[0], `BCHR_OFF_IO, v); check(v, 32'h0000_0101);
        end
        check({31'h0, cl_ok === 2'h3}, 32'h0000_0001);
        wr(1'b0, `BCHR_OFF_CLASS, 4'hF, 32'hFFFF_FFFF);
        rd(1'b0, `BCHR_OFF_CLASS, v); check(v, 32'h0604_0000);
        wr(1'b0, `BCHR_OFF_MISC, 4'hF, 32'hFFFF_FFFF);
        rd(1'b0, `BCHR_OFF_MISC, v); check(v, 32'h0081_FFFF);
        check({30'h0, cl_ok}, 32'h0000_0002);
        wr(1'b0, `BCHR_OFF_MISC, 4'h1, 32'hAAAA_AA10);
        rd(1'b0, `BCHR_OFF_MISC, v); check(v, 32'h0081_FF10);
        check({cl_len, up_t[7:0], 6'h00, cl_ok}, 32'h0010_FF03);
        wr(1'b0, `BCHR_OFF_BUS, 4'h5, 32'hAABB_CCDD);
        wr(1'b1, `BCHR_OFF_BUS, 4'hF, 32'h4433_2211);
        rd(1'b1, `BCHR_OFF_BUS, v); check(v, 32'h4433_2211);
        rd(1'b0, `BCHR_OFF_BUS, v); check(v, 32'h00BB_00DD);
        check({up_b, dn_b}, 32'h11DD_2200);
        check({hi_b, dn_t}, 32'h33BB_4400);
        rd(1'b0, 8'h04, v); check(v, 32'h0000_0000);
        @(posedge clk); #1 check(rdata, 32'h0000_0000);
        wr(1'b0, `BCHR_OFF_IO, 4'hF, 32'hFFFF_7F5E);
        rd(1'b0, `BCHR_OFF_IO, v); check(v, 32'h0000_7151);
        @(posedge clk);
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            io_addr <= io_tab[i];
            @(posedge clk);
            #1 check({30'h0, hit}, {30'h0, hit_tab[i]});
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
